//--- rtl/emi_top.sv
// External memory bus interface: control registers, access sequencer, pins.
// Assumes an external transparent address latch and a CPU access port.
//
// Operation
// - Enable bit hands pins to the interface
// - Interface overrides port direction bits when enabled
// - Decode address; only external targets get read and write strobes
// - Latch strobe falls on valid address, stays low
// - Internal accesses never assert read or write
// - Disabled: high addresses never alias internal SRAM
// - Low pins multiplex address and data; high bus
// - Keeper holds last driven value when tri-stated
// - No keeper: bus floats after external read until next
// - Pull-ups follow port output bits
// - Two sectors, each with its own wait setting
// - Final-period latch pulse only if RAM follows
// - Legacy mode: no extra registers, sectors, keeper
// - Legacy mode: upper waits 0/1, control pins outputs
// - Legacy single wait bit adds one strobe cycle
// - System control resets to zero
// - Wait codes: none, one, two, two plus hold
// - Sector limit in 0x2000 steps, zero means upper
// - High mask releases top port pins
// - Keeper enable independent of interface enable
`timescale 1ns/1ns
`default_nettype none
module emi_top
  import emi_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        nrst_i,
  input  wire logic        compat_i,
  input  wire logic [1:0]  reg_sel_i,
  input  wire logic        reg_we_i,
  input  wire logic [7:0]  reg_wdata_i,
  output logic [7:0]       reg_rdata_o,
  input  wire logic        acc_req_i,
  input  wire logic        acc_we_i,
  input  wire logic [15:0] acc_addr_i,
  input  wire logic [7:0]  acc_wdata_i,
  input  wire logic        acc_next_ram_i,
  output logic             acc_ready_o,
  output logic             acc_done_o,
  output logic             acc_ext_o,
  output logic [7:0]       acc_rdata_o,
  input  wire logic [7:0]  lo_port_out_i,
  input  wire logic [7:0]  lo_port_ddr_i,
  input  wire logic [7:0]  hi_port_out_i,
  input  wire logic [7:0]  hi_port_ddr_i,
  input  wire logic [2:0]  ctl_port_out_i,
  input  wire logic [2:0]  ctl_port_ddr_i,
  input  wire logic [7:0]  ad_i,
  output logic [7:0]       ad_o,
  output logic [7:0]       ad_oe_o,
  output logic [7:0]       ad_pullup_o,
  output logic             ad_keep_en_o,
  output logic [7:0]       ad_keep_o,
  output logic [7:0]       addr_high_o,
  output logic [7:0]       addr_high_oe_o,
  output logic             ale_o,
  output logic             rd_n_o,
  output logic             wr_n_o,
  output logic [2:0]       ctl_oe_o
);

  emi_cfg_if cfg ();

  // Control registers
  logic [7:0]    sysctl_ff;
  logic [7:0]    ctrla_ff;
  logic [7:0]    ctrlb_ff;
  logic [7:0]    reg_rdata_ff;
  // Sequencer
  emi_state_type state_ff;
  emi_state_type nxt_state;
  logic [1:0]    cnt_ff;
  logic [1:0]    nxt_cnt;
  logic [15:0]   addr_ff;
  logic [7:0]    wdata_ff;
  logic          we_ff;
  logic          ext_ff;
  logic [1:0]    wait_ff;
  logic          nram_ff;
  logic [7:0]    rdata_ff;
  logic [7:0]    ad_val_ff;
  logic          ad_drv_ff;
  logic [7:0]    keep_ff;
  // Pin input synchroniser
  logic [7:0]    ad_s1_ff;
  logic [7:0]    ad_s2_ff;
  logic [7:0]    ad_s3_ff;
  logic [7:0]    ad_stable_ff;

  wire logic       enable;
  wire logic       req_ext;
  wire logic [1:0] req_wait;
  wire logic [1:0] wait_cycles;
  wire logic       wr_sys;
  wire logic       wr_ca;
  wire logic       wr_cb;
  wire logic [7:0] reg_rmux;
  wire logic       in_strobe;
  wire logic       strobe_end;
  wire logic [2:0] ctl_val;
  wire logic       ad_agree;

  // Effective configuration; legacy mode strips the extended features
  assign enable          = sysctl_ff[EMI_SYS_ENABLE_BIT];
  assign cfg.enable      = enable;
  assign cfg.upper_wait  = {ctrla_ff[EMI_CA_UPPER_W_HI] & ~compat_i,
                            sysctl_ff[EMI_SYS_UPPER_W_LO]};
  assign cfg.lower_wait  = ctrla_ff[EMI_CA_LOWER_W_HI:EMI_CA_LOWER_W_LO];
  assign cfg.limit       = compat_i ? 3'h0 :
                           ctrla_ff[EMI_CA_LIMIT_HI:EMI_CA_LIMIT_LO];
  assign cfg.mask        = compat_i ? 3'h0 :
                           ctrlb_ff[EMI_CB_MASK_HI:0];
  assign cfg.keeper      = ~compat_i & ctrlb_ff[EMI_CB_KEEPER_BIT];

  // Register port decode; extended registers vanish in legacy mode
  assign wr_sys   = reg_we_i && (reg_sel_i == EMI_SEL_SYSCTL);
  assign wr_ca    = reg_we_i && (reg_sel_i == EMI_SEL_CTRL_A) && !compat_i;
  assign wr_cb    = reg_we_i && (reg_sel_i == EMI_SEL_CTRL_B) && !compat_i;
  assign reg_rmux = (reg_sel_i == EMI_SEL_SYSCTL) ? sysctl_ff :
                    compat_i ? 8'h00 :
                    (reg_sel_i == EMI_SEL_CTRL_A) ? ctrla_ff :
                    (reg_sel_i == EMI_SEL_CTRL_B) ? ctrlb_ff : 8'h00;

  always_ff @(posedge core_clk_i)
  begin
    if (!nrst_i)
    begin
      sysctl_ff    <= EMI_SYS_RESET;
      ctrla_ff     <= EMI_CA_RESET;
      ctrlb_ff     <= EMI_CB_RESET;
      reg_rdata_ff <= 8'h00;
    end
    else
    begin
      if (wr_sys)
        sysctl_ff <= reg_wdata_i;
      if (wr_ca)
        ctrla_ff <= reg_wdata_i & EMI_CA_WMASK;
      if (wr_cb)
        ctrlb_ff <= reg_wdata_i & EMI_CB_WMASK;
      reg_rdata_ff <= reg_rmux;
    end
  end

  assign reg_rdata_o = reg_rdata_ff;

  emi_sector_sel u_sector (
    .cfg      (cfg),
    .addr_i   (acc_addr_i),
    .is_ext_o (req_ext),
    .wait_o   (req_wait)
  );

  // Strobe length beyond the first cycle; codes 10 and 11 both add two
  // Captured code, so a changing address cannot stretch the strobe
  assign wait_cycles = (wait_ff == EMI_WAIT_NONE) ? 2'h0 :
                       (wait_ff == EMI_WAIT_ONE)  ? 2'h1 : 2'h2;

  assign in_strobe  = (state_ff == EMI_ST_STROBE);
  assign strobe_end = in_strobe && (cnt_ff == 2'h0);

  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    case (state_ff)
      EMI_ST_IDLE:
        if (acc_req_i)
          // Disabled: answer locally so nothing reaches the pins
          nxt_state = enable ? EMI_ST_ADDR : EMI_ST_TAIL;
      EMI_ST_ADDR:
        if (ext_ff)
        begin
          nxt_state = EMI_ST_STROBE;
          nxt_cnt   = wait_cycles;
        end
        else
          nxt_state = EMI_ST_TAIL;
      EMI_ST_STROBE:
        if (cnt_ff == 2'h0)
          nxt_state = (wait_ff == EMI_WAIT_TWO_HOLD) ? EMI_ST_HOLD :
                                                       EMI_ST_TAIL;
        else
          nxt_cnt = cnt_ff - 2'h1;
      EMI_ST_HOLD:
        nxt_state = EMI_ST_TAIL;
      EMI_ST_TAIL:
        nxt_state = EMI_ST_IDLE;
      default:
        nxt_state = EMI_ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!nrst_i)
    begin
      state_ff <= EMI_ST_IDLE;
      cnt_ff   <= 2'h0;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
    end
  end

  // Request capture
  always_ff @(posedge core_clk_i)
  begin
    if (!nrst_i)
    begin
      addr_ff  <= 16'h0000;
      wdata_ff <= 8'h00;
      we_ff    <= 1'b0;
      ext_ff   <= 1'b0;
      wait_ff  <= 2'h0;
      nram_ff  <= 1'b0;
    end
    else if (state_ff == EMI_ST_IDLE && acc_req_i)
    begin
      addr_ff  <= acc_addr_i;
      wdata_ff <= acc_wdata_i;
      we_ff    <= acc_we_i;
      ext_ff   <= req_ext;
      wait_ff  <= req_wait;
      nram_ff  <= acc_next_ram_i;
    end
  end

  // Low bus value: address in the address phase, then write data.
  // After an external read the bus stays released until the next access.
  always_ff @(posedge core_clk_i)
  begin
    if (!nrst_i)
    begin
      ad_val_ff <= 8'h00;
      ad_drv_ff <= 1'b0;
    end
    else if (state_ff == EMI_ST_IDLE && acc_req_i && enable)
    begin
      ad_val_ff <= acc_addr_i[7:0];
      ad_drv_ff <= 1'b1;
    end
    else if (state_ff == EMI_ST_ADDR && ext_ff)
    begin
      ad_val_ff <= wdata_ff;
      ad_drv_ff <= we_ff;
    end
  end

  // Keeper copy of the last value the interface drove
  always_ff @(posedge core_clk_i)
  begin
    if (!nrst_i)
      keep_ff <= 8'h00;
    else if (ad_drv_ff && enable)
      keep_ff <= ad_val_ff;
  end

  assign ad_keep_en_o = cfg.keeper;
  assign ad_keep_o    = keep_ff;

  // Read data crosses in from the pins through three stages
  always_ff @(posedge core_clk_i)
  begin
    if (!nrst_i)
    begin
      ad_s1_ff     <= 8'h00;
      ad_s2_ff     <= 8'h00;
      ad_s3_ff     <= 8'h00;
      ad_stable_ff <= 8'h00;
    end
    else
    begin
      ad_s1_ff <= ad_i;
      ad_s2_ff <= ad_s1_ff;
      ad_s3_ff <= ad_s2_ff;
      if (ad_agree)
        ad_stable_ff <= ad_s3_ff;
    end
  end

  assign ad_agree = (ad_s2_ff == ad_s3_ff);

  // Data must settle three cycles before strobe end; choose waits for it
  always_ff @(posedge core_clk_i)
  begin
    if (!nrst_i)
      rdata_ff <= 8'h00;
    else if (state_ff == EMI_ST_IDLE && acc_req_i)
      rdata_ff <= 8'h00;
    else if (strobe_end && !we_ff)
      rdata_ff <= ad_agree ? ad_s3_ff : ad_stable_ff;
  end

  // Read and write strobes only for external targets; latch strobe low while they run
  assign ale_o  = enable && ((state_ff == EMI_ST_ADDR) ||
                  (state_ff == EMI_ST_TAIL && nram_ff));
  assign rd_n_o = !(in_strobe && ext_ff && !we_ff);
  assign wr_n_o = !(in_strobe && ext_ff && we_ff);
  assign ctl_val = {wr_n_o, rd_n_o, ale_o};

  // The external latch is transparent while ale_o is high
  emi_pin_mux u_pins (
    .cfg            (cfg),
    .ad_val_i       (ad_val_ff),
    .ad_drive_i     (ad_drv_ff),
    .hi_addr_i      (addr_ff[15:8]),
    .ctl_val_i      (ctl_val),
    .lo_port_out_i  (lo_port_out_i),
    .lo_port_ddr_i  (lo_port_ddr_i),
    .hi_port_out_i  (hi_port_out_i),
    .hi_port_ddr_i  (hi_port_ddr_i),
    .ctl_port_out_i (ctl_port_out_i),
    .ctl_port_ddr_i (ctl_port_ddr_i),
    .ad_o           (ad_o),
    .ad_oe_o        (ad_oe_o),
    .ad_pullup_o    (ad_pullup_o),
    .hi_o           (addr_high_o),
    .hi_oe_o        (addr_high_oe_o),
    .ctl_o          (),
    .ctl_oe_o       (ctl_oe_o)
  );

  assign acc_ready_o = (state_ff == EMI_ST_IDLE);
  assign acc_done_o  = (state_ff == EMI_ST_TAIL);
  assign acc_ext_o   = ext_ff && enable;
  assign acc_rdata_o = rdata_ff;

  // Checks
  chk_enable_drives: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    (state_ff == EMI_ST_ADDR && enable) |-> (ad_oe_o == 8'hff))
    else $error("address phase does not drive low bus");

  chk_ale_fall_addr: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    $fell(ale_o) && in_strobe |-> $past(ad_o) == addr_ff[7:0])
    else $error("latch strobe fell without valid low address");

  chk_ale_low_xfer: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    (in_strobe || state_ff == EMI_ST_HOLD) |-> !ale_o)
    else $error("latch strobe high during data transfer");

  chk_int_no_strobe: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    (state_ff == EMI_ST_IDLE && acc_req_i && !req_ext)
      |=> (rd_n_o && wr_n_o) [*3])
    else $error("strobe asserted for internal access");

  chk_no_alias: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    (state_ff == EMI_ST_IDLE && acc_req_i && !enable)
      |=> acc_done_o && !ale_o && rd_n_o && wr_n_o ##1 acc_rdata_o == 8'h00)
    else $error("disabled access reached the pins");

  chk_zero_wait: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    $fell(rd_n_o) && wait_ff == EMI_WAIT_NONE |=> rd_n_o)
    else $error("zero wait read strobe not one cycle");

  chk_two_wait: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    $fell(wr_n_o) && wait_ff[1] |-> !wr_n_o [*3] ##1 wr_n_o)
    else $error("two wait write strobe not three cycles");

  chk_hold_cycle: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    strobe_end && wait_ff == EMI_WAIT_TWO_HOLD
      |=> state_ff == EMI_ST_HOLD && !ale_o ##1 acc_done_o)
    else $error("missing hold cycle before new address");

  chk_tail_ale: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    acc_done_o && !nram_ff |-> !ale_o)
    else $error("final period latch pulse without RAM access");

  chk_legacy_strip: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    compat_i |-> !ad_keep_en_o && cfg.limit == 3'h0 && !cfg.upper_wait[1])
    else $error("extended features active in legacy mode");

  chk_reset_zero: assert property (
    @(posedge core_clk_i)
    !$past(nrst_i) |-> sysctl_ff == 8'h00 && !ale_o && rd_n_o)
    else $error("system control not cleared by reset");

endmodule
`default_nettype wire

//--- rtl/emi_pkg.sv
// Constants, field layouts and types of the external memory bus interface.
// Assumes one core clock and a synchronous active-low reset around it.
package emi_pkg;

  // Register selects on the control register port
  localparam logic [1:0] EMI_SEL_SYSCTL = 2'h0;
  localparam logic [1:0] EMI_SEL_CTRL_A = 2'h1;
  localparam logic [1:0] EMI_SEL_CTRL_B = 2'h2;

  // System control fields
  localparam int         EMI_SYS_ENABLE_BIT  = 7;
  localparam int         EMI_SYS_UPPER_W_LO  = 6;
  localparam logic [7:0] EMI_SYS_RESET       = 8'h00;

  // Control A fields
  localparam int         EMI_CA_LIMIT_HI     = 6;
  localparam int         EMI_CA_LIMIT_LO     = 4;
  localparam int         EMI_CA_LOWER_W_HI   = 3;
  localparam int         EMI_CA_LOWER_W_LO   = 2;
  localparam int         EMI_CA_UPPER_W_HI   = 1;
  localparam logic [7:0] EMI_CA_WMASK        = 8'h7e;
  localparam logic [7:0] EMI_CA_RESET        = 8'h00;

  // Control B fields
  localparam int         EMI_CB_KEEPER_BIT   = 7;
  localparam int         EMI_CB_MASK_HI      = 2;
  localparam logic [7:0] EMI_CB_WMASK        = 8'h87;
  localparam logic [7:0] EMI_CB_RESET        = 8'h00;

  // Address map
  localparam logic [15:0] EMI_EXT_BASE       = 16'h1100;
  localparam int          EMI_SECTOR_SHIFT   = 13;
  localparam logic [2:0]  EMI_MASK_ALL       = 3'h7;

  // Pin input synchroniser depth
  localparam int          EMI_SYNC_STAGES    = 3;

  typedef enum logic [1:0] {
    EMI_WAIT_NONE     = 2'b00,
    EMI_WAIT_ONE      = 2'b01,
    EMI_WAIT_TWO      = 2'b10,
    EMI_WAIT_TWO_HOLD = 2'b11
  } emi_wait_type;

  typedef enum logic [2:0] {
    EMI_ST_IDLE   = 3'b000,
    EMI_ST_ADDR   = 3'b001,
    EMI_ST_STROBE = 3'b011,
    EMI_ST_HOLD   = 3'b110,
    EMI_ST_TAIL   = 3'b010
  } emi_state_type;

endpackage

//--- rtl/emi_cfg_if.sv
// Effective configuration passed from the register file to the helpers.
// Assumes the driving side has already applied legacy mode limits.
`timescale 1ns/1ns
`default_nettype none
interface emi_cfg_if;
  logic       enable;
  logic       keeper;
  logic [1:0] upper_wait;
  logic [1:0] lower_wait;
  logic [2:0] limit;
  logic [2:0] mask;

  modport ctrl (output enable, keeper, upper_wait, lower_wait, limit, mask);
  modport user (input enable, keeper, upper_wait, lower_wait, limit, mask);
endinterface
`default_nettype wire

//--- rtl/emi_sector_sel.sv
// Internal/external decode and per-sector wait selection.
// Assumes a stable address for the cycle in which it is sampled.
`timescale 1ns/1ns
`default_nettype none
module emi_sector_sel
  import emi_pkg::*;
(
  emi_cfg_if.user          cfg,
  input  wire logic [15:0] addr_i,
  output logic             is_ext_o,
  output logic [1:0]       wait_o
);

  wire logic [15:0] limit_addr;
  wire logic        upper_hit;

  assign is_ext_o   = (addr_i >= EMI_EXT_BASE);
  assign limit_addr = {cfg.limit, 13'h0000};
  // Limit zero puts the whole external space in the upper sector
  assign upper_hit  = (cfg.limit == 3'h0) || (addr_i >= limit_addr);
  assign wait_o     = upper_hit ? cfg.upper_wait : cfg.lower_wait;

endmodule
`default_nettype wire

//--- rtl/emi_pin_mux.sv
// Pin override between the interface and the general purpose port logic.
// Assumes port output and direction bits come from the same clock domain.
`timescale 1ns/1ns
`default_nettype none
module emi_pin_mux
  import emi_pkg::*;
(
  emi_cfg_if.user         cfg,
  input  wire logic [7:0] ad_val_i,
  input  wire logic       ad_drive_i,
  input  wire logic [7:0] hi_addr_i,
  input  wire logic [2:0] ctl_val_i,
  input  wire logic [7:0] lo_port_out_i,
  input  wire logic [7:0] lo_port_ddr_i,
  input  wire logic [7:0] hi_port_out_i,
  input  wire logic [7:0] hi_port_ddr_i,
  input  wire logic [2:0] ctl_port_out_i,
  input  wire logic [2:0] ctl_port_ddr_i,
  output logic [7:0]      ad_o,
  output logic [7:0]      ad_oe_o,
  output logic [7:0]      ad_pullup_o,
  output logic [7:0]      hi_o,
  output logic [7:0]      hi_oe_o,
  output logic [2:0]      ctl_o,
  output logic [2:0]      ctl_oe_o
);

  wire logic [3:0] hi_bits;

  // Mask n releases the top n pins, mask 7 releases all of them
  assign hi_bits = (cfg.mask == EMI_MASK_ALL) ? 4'h0 :
                   (4'h8 - {1'b0, cfg.mask});

  genvar i;
  generate
    for (i = 0; i < 8; i++)
    begin : g_bit
      wire logic hi_use;
      assign hi_use     = cfg.enable && (4'(i) < hi_bits);
      assign hi_o[i]    = hi_use ? hi_addr_i[i] : hi_port_out_i[i];
      assign hi_oe_o[i] = hi_use ? 1'b1 : hi_port_ddr_i[i];
      assign ad_o[i]    = cfg.enable ? ad_val_i[i] : lo_port_out_i[i];
      assign ad_oe_o[i] = cfg.enable ? ad_drive_i : lo_port_ddr_i[i];
      // Pull-ups follow the port bit whenever the line is not driven
      assign ad_pullup_o[i] = ~ad_oe_o[i] & lo_port_out_i[i];
    end
  endgenerate

  assign ctl_o    = cfg.enable ? ctl_val_i : ctl_port_out_i;
  assign ctl_oe_o = cfg.enable ? 3'h7 : ctl_port_ddr_i;

endmodule
`default_nettype wire

//--- bench/emi_sram_model.sv
// External SRAM behind a transparent address latch, with bus resolution.
// Assumes the pin values of the interface and returns the bus level.
`timescale 1ns/1ns
`default_nettype none
module emi_sram_model
(
  input  wire logic       clk_i,
  input  wire logic [7:0] ad_o_i,
  input  wire logic [7:0] ad_oe_i,
  input  wire logic [7:0] pull_i,
  input  wire logic       keep_en_i,
  input  wire logic [7:0] keep_i,
  input  wire logic [7:0] hi_i,
  input  wire logic       ale_i,
  input  wire logic       rd_n_i,
  input  wire logic       wr_n_i,
  output logic [7:0]      bus_o
);
  logic [7:0] mem [0:65535];
  logic [7:0] addr_lat;
  logic [7:0] last_ff;
  logic [7:0] rdq;
  // Transparent while strobe high, holds low byte after
  // Taken at the edge where ale_i falls: models the latch hold time
  always_ff @(posedge clk_i)
    if (ale_i)
      addr_lat <= bus_o;
  assign rdq = mem[{hi_i, addr_lat}];
  always @(posedge wr_n_i)
    mem[{hi_i, addr_lat}] <= bus_o;
  // Floating bits toggle so a stale value never looks valid
  always_comb
    for (int i = 0; i < 8; i++)
      bus_o[i] = ad_oe_i[i] ? ad_o_i[i] : !rd_n_i ? rdq[i] :
                 keep_en_i ? keep_i[i] : pull_i[i] ? 1'b1 : ~last_ff[i];
  always_ff @(posedge clk_i)
    last_ff <= bus_o;
endmodule
`default_nettype wire

//--- bench/tb_external_memory_bus_interface.sv
// Self-checking bench of the external memory bus interface.
// Assumes the design top and the SRAM model in the bench folder.
`timescale 1ns/1ns
`default_nettype none
module tb_external_memory_bus_interface;
  import emi_pkg::*;
  logic core_clk_i, nrst_i, compat_i, reg_we_i, acc_req_i, acc_we_i;
  logic acc_next_ram_i, acc_ready_o, acc_done_o, acc_ext_o, ad_keep_en_o;
  logic ale_o, rd_n_o, wr_n_o;
  logic [1:0]  reg_sel_i;
  logic [2:0]  ctl_port_out_i, ctl_port_ddr_i, ctl_oe_o;
  logic [15:0] acc_addr_i;
  logic [7:0]  reg_wdata_i, reg_rdata_o, acc_wdata_i, acc_rdata_o, ad_i;
  logic [7:0]  lo_port_out_i, lo_port_ddr_i, hi_port_out_i, hi_port_ddr_i;
  logic [7:0]  ad_o, ad_oe_o, ad_pullup_o, ad_keep_o, addr_high_o;
  logic [7:0]  addr_high_oe_o, r, d, hm;
  logic [15:0] a;
  logic [2:0]  lim;
  logic [1:0]  lw, uw, w;
  int          mismatches, tests_run;
  logic [31:0] seed = 32'hd32c1ff1;

  emi_top u_dut (.core_clk_i, .nrst_i, .compat_i, .reg_sel_i, .reg_we_i,
    .reg_wdata_i, .reg_rdata_o, .acc_req_i, .acc_we_i, .acc_addr_i,
    .acc_wdata_i, .acc_next_ram_i, .acc_ready_o, .acc_done_o, .acc_ext_o,
    .acc_rdata_o, .lo_port_out_i, .lo_port_ddr_i, .hi_port_out_i,
    .hi_port_ddr_i, .ctl_port_out_i, .ctl_port_ddr_i, .ad_i, .ad_o,
    .ad_oe_o, .ad_pullup_o, .ad_keep_en_o, .ad_keep_o, .addr_high_o,
    .addr_high_oe_o, .ale_o, .rd_n_o, .wr_n_o, .ctl_oe_o);
  emi_sram_model u_mem (.clk_i(core_clk_i), .ad_o_i(ad_o),
    .ad_oe_i(ad_oe_o), .pull_i(ad_pullup_o), .keep_en_i(ad_keep_en_o),
    .keep_i(ad_keep_o), .hi_i(addr_high_o), .ale_i(ale_o),
    .rd_n_i(rd_n_o), .wr_n_i(wr_n_o), .bus_o(ad_i));

  initial
  begin
    core_clk_i = 1'b0;
    forever #50 core_clk_i = ~core_clk_i;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic int exp_lat(input logic [1:0] w);
    return (w == 2'h3) ? 6 : 3 + w;
  endfunction
  function automatic int exp_stb(input logic [1:0] w);
    return (w == 2'h0) ? 1 : (w == 2'h1) ? 2 : 3;
  endfunction
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    tests_run++;
    if (s !== e)
    begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic end_of_test();
    $display("Counts: %0d compared, %0d bad", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wr_reg(input logic [1:0] s, input logic [7:0] v);
    @(posedge core_clk_i);
    reg_sel_i <= s;
    reg_wdata_i <= v;
    reg_we_i <= 1'b1;
    @(posedge core_clk_i);
    reg_we_i <= 1'b0;
  endtask
  task automatic rd_reg(input logic [1:0] s, output logic [7:0] v);
    @(posedge core_clk_i);
    reg_sel_i <= s;
    @(posedge core_clk_i);
    @(negedge core_clk_i);
    v = reg_rdata_o;
  endtask
  // One access; zero expected strobes marks internal or disabled
  task automatic acc(input logic [15:0] a, input logic we, nr,
                     input logic [7:0] d, input int el, es);
    int lat;
    int stb;
    @(posedge core_clk_i);
    acc_req_i <= 1'b1;
    acc_we_i <= we;
    acc_addr_i <= a;
    acc_wdata_i <= d;
    acc_next_ram_i <= nr;
    @(posedge core_clk_i);
    acc_req_i <= 1'b0;
    stb = 0;
    for (lat = 1; lat < 20; lat++)
    begin
      @(negedge core_clk_i);
      stb += int'(!rd_n_o) + int'(!wr_n_o);
      if (lat == 1)
        chk(acc_ready_o, 1'b0);
      if (!rd_n_o)
        chk(ad_oe_o, 8'h00);
      if (lat == 1 && es > 0)
      begin
        chk({ale_o, ad_o}, {1'b1, a[7:0]});
        chk(addr_high_o, a[15:8]);
      end
      if (lat == 2 && es > 0)
        chk(ale_o, 1'b0);
      if (acc_done_o === 1'b1)
        break;
    end
    if (lat == 20)
    begin
      mismatches++;
      end_of_test();
    end
    chk(16'(lat), 16'(el));
    chk(16'(stb), 16'(es));
    if (es > 0)
      chk(ale_o, nr);
  endtask

  initial
  begin
    {nrst_i, compat_i, reg_we_i, acc_req_i, acc_we_i, acc_next_ram_i} = '0;
    {reg_sel_i, reg_wdata_i, acc_addr_i, acc_wdata_i} = '0;
    {lo_port_out_i, lo_port_ddr_i, hi_port_out_i} = rnd();
    {hi_port_ddr_i, ctl_port_out_i, ctl_port_ddr_i} = rnd();
    repeat (5) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    for (int s = 0; s < 3; s++)
    begin
      rd_reg(s[1:0], r);
      chk(r, EMI_SYS_RESET);
    end
    chk({ale_o, rd_n_o, wr_n_o}, 3'b011);
    chk({ctl_oe_o, ad_oe_o}, {ctl_port_ddr_i, lo_port_ddr_i});
    $display("Test reset done");
    for (int i = 0; i < 8; i++)
    begin
      d = rnd();
      lo_port_out_i <= rnd();
      wr_reg(2'h1, d);
      rd_reg(2'h1, r);
      chk(r, d & EMI_CA_WMASK);
      wr_reg(2'h2, d);
      rd_reg(2'h2, r);
      chk(r, d & EMI_CB_WMASK);
      chk(ad_keep_en_o, d[7]);
      wr_reg(2'h3, d);
      rd_reg(2'h0, r);
      chk(r, 8'h00);
      chk(ad_pullup_o, ~lo_port_ddr_i & lo_port_out_i);
    end
    wr_reg(2'h1, 8'h00);
    wr_reg(2'h2, 8'h00);
    acc(16'h1100 + 16'(rnd() % 32'hef00), 1'b0, 1'b1, 8'h00, 1, 0);
    chk({acc_ext_o, acc_rdata_o}, 9'h000);
    $display("Test registers and disabled done");
    wr_reg(2'h0, 8'h80);
    @(negedge core_clk_i);
    chk(ctl_oe_o, 3'h7);
    for (int m = 0; m < 8; m++)
    begin
      hi_port_ddr_i <= rnd();
      wr_reg(2'h2, 8'(m));
      @(negedge core_clk_i);
      hm = (m == 7) ? 8'h00 : 8'hff >> m;
      chk(addr_high_oe_o, hm | (hi_port_ddr_i & ~hm));
    end
    wr_reg(2'h2, 8'h00);
    for (int i = 0; i < 8; i++)
    begin
      w = 2'(i);
      wr_reg(2'h0, {1'b1, w[0], 6'h00});
      wr_reg(2'h1, {6'h00, w[1], 1'b0});
      a = 16'h1100 + 16'(rnd() % 32'hef00);
      d = rnd();
      acc(a, 1'b1, rnd() & 1, d, exp_lat(w), exp_stb(w));
      chk(u_mem.mem[a], d);
      chk({acc_ext_o, ad_keep_o}, {1'b1, d});
      acc(a, 1'b0, rnd() & 1, 8'h00, exp_lat(w), exp_stb(w));
      acc(16'(rnd() % 32'h1100), rnd() & 1, 1'b1, rnd(), 2, 0);
      chk({acc_ext_o, acc_rdata_o}, 9'h000);
    end
    $display("Test waits and internal done");
    for (int i = 0; i < 8; i++)
    begin
      lim = 3'(rnd() % 7 + 1);
      {lw, uw} = rnd();
      wr_reg(2'h0, {1'b1, uw[0], 6'h00});
      wr_reg(2'h1, {1'b0, lim, lw, uw[1], 1'b0});
      a = {lim, 13'h0000} - 16'(rnd() & 1);
      w = (a < {lim, 13'h0000}) ? lw : uw;
      acc(a, 1'b0, 1'b0, 8'h00, exp_lat(w), exp_stb(w));
    end
    $display("Test sectors done");
    wr_reg(2'h1, 8'h7e);
    wr_reg(2'h2, 8'h80);
    compat_i <= 1'b1;
    rd_reg(2'h1, r);
    chk({r, ad_keep_en_o}, 9'h000);
    for (int i = 0; i < 2; i++)
    begin
      wr_reg(2'h0, {1'b1, i[0], 6'h00});
      a = 16'h1100 + 16'(rnd() % 32'hef00);
      acc(a, 1'b0, 1'b1, 8'h00, 3 + i, 1 + i);
      chk(ctl_oe_o, 3'h7);
    end
    $display("Test legacy mode done");
    end_of_test();
  end
endmodule
`default_nettype wire
